// ---- src/pdpwm_pkg.sv ----
// Package with register map, field layout and timing constants of the pulse-division PWM.
package pdpwm_pkg;
    // Register byte addresses on the APB slave.
    localparam logic [7:0]  PDPWM_OFS_CONTROL = 8'h00;
    localparam logic [7:0]  PDPWM_OFS_UPPER   = 8'h04;
    localparam logic [7:0]  PDPWM_OFS_LOWER   = 8'h08;
    // Field layout of the control register.
    localparam int          PDPWM_CLKSEL_POS  = 0;
    localparam logic [7:0]  PDPWM_CTRL_RSVD   = 8'hfe;
    // Reset value of the combined width data and the value read back from data registers.
    localparam logic [15:0] PDPWM_WIDTH_RESET = 16'hc000;
    localparam logic [7:0]  PDPWM_DATA_READ   = 8'hff;
    // Pulse structure: 64 pulses of 256 steps each, a step being one or two system clocks.
    localparam int          PDPWM_PULSES      = 64;
    localparam int          PDPWM_PULSE_STEPS = 256;
    // Offset added to the data value, and the continuous-high threshold.
    localparam logic [14:0] PDPWM_HIGH_OFFSET = 15'h0040;
    localparam logic [15:0] PDPWM_FULL_HIGH   = 16'hffc0;
    // System clocks per step: one for clock select 0, two for clock select 1.
    localparam logic [1:0]  PDPWM_STEP_DIV0   = 2'h1;
    localparam logic [1:0]  PDPWM_STEP_DIV1   = 2'h2;

    // Bundle of the APB request fields.
    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
        logic [3:0]  strb;
    } pdpwm_req_s;
endpackage : pdpwm_pkg

// ---- src/pdpwm_step_gen.sv ----
// Step tick generator that divides the system clock by the selected prescale.
`timescale 1ns/1ps
`default_nettype none
module pdpwm_step_gen
    import pdpwm_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Clock selection.
    input  wire logic clock_select_bit,
    // One-cycle step tick.
    output var  logic step_tick
);
    logic [1:0] count;
    logic [1:0] next_count;
    logic       next_step_tick;

    // Count system clocks per step; select 1 doubles the step length.
    always_comb begin
        logic [1:0] div;
        div = clock_select_bit ? PDPWM_STEP_DIV1 : PDPWM_STEP_DIV0; // [RQ1] [RQ2]
        next_step_tick = 1'b0;
        next_count = count + 2'h1;
        if (next_count >= div) begin
            next_count = 2'h0;
            next_step_tick = 1'b1;
        end
    end

    // Register the counter and the tick.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count     <= 2'h0;
            step_tick <= 1'b0;
        end else begin
            count     <= next_count;
            step_tick <= next_step_tick;
        end
    end
endmodule // pdpwm_step_gen
`default_nettype wire

// ---- src/pdpwm_wave_gen.sv ----
// Waveform generator that spreads the high steps over 64 pulses per period.
`timescale 1ns/1ps
`default_nettype none
module pdpwm_wave_gen
    import pdpwm_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // Step tick and latched width data.
    input  wire logic        step_tick,
    input  wire logic [15:0] width_data,
    // Waveform level before the output flop.
    output var  logic        wave
);
    logic [13:0] pos;
    logic [13:0] next_pos;
    logic [15:0] active;
    logic [15:0] next_active;

    // Pulse count is the slot index; phase is the step inside a pulse.
    function automatic logic high_at(input logic [15:0] d, input logic [13:0] p);
        logic [14:0] total;
        logic [8:0]  base;
        logic [5:0]  extra;
        logic [5:0]  pulse;
        logic [7:0]  phase;
        logic [8:0]  len;
        logic [6:0]  rev;
        total = {1'b0, d[13:0]} + PDPWM_HIGH_OFFSET; // [RQ11]
        base  = total[14:6];
        extra = total[5:0];
        pulse = p[13:8];
        phase = p[7:0];
        // Bit-reversed slot order scatters the leftover steps evenly.
        rev = {1'b0, pulse[0], pulse[1], pulse[2], pulse[3], pulse[4], pulse[5]};
        len = base + ((rev < {1'b0, extra}) ? 9'h001 : 9'h000); // [RQ14]
        high_at = (d >= PDPWM_FULL_HIGH) || ({1'b0, phase} < len); // [RQ12]
    endfunction

    // Advance on each step; new data is taken only at period start.
    always_comb begin
        next_pos = pos;
        next_active = active;
        if (step_tick) begin
            next_pos = pos + 14'h0001; // [RQ10]
            if (pos == 14'h3fff) begin
                next_active = width_data; // [RQ8]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos    <= 14'h0000;
            active <= PDPWM_WIDTH_RESET; // [RQ9]
        end else begin
            pos    <= next_pos;
            active <= next_active;
        end
    end

    assign wave = high_at(active, pos);
endmodule // pdpwm_wave_gen
`default_nettype wire

// ---- src/pdpwm_top.sv ----
// Top level of the pulse-division PWM with its APB register slave.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1 - Select 0: step is one system clock.
// RQ2 - Select 1: step is two system clocks.
// RQ3 - Control upper bits read one, ignore writes.
// RQ4 - Width is 14 bits: upper 6, lower 8.
// RQ5 - Width registers always read all ones.
// RQ6 - Software uses byte access on width registers.
// RQ7 - Software writes lower before upper.
// RQ8 - Upper write latches value; updated at period.
// RQ9 - Width data resets to C000.
// RQ10 - Each period holds 64 pulses.
// RQ11 - High steps equal data plus 64.
// RQ12 - Data FFC0 to FFFF keeps output high.
// RQ13 - Software enables pin function before use.
// RQ14 - Pulses of 256 steps, high spread evenly.
module pdpwm_top
    import pdpwm_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Waveform output.
    output logic             pwm_out
);
    pdpwm_req_s  req;
    logic        clock_select_bit;
    logic        next_clock_select_bit;
    logic [7:0]  lower_hold;
    logic [7:0]  next_lower_hold;
    logic [15:0] width_data;
    logic [15:0] next_width_data;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_pwm_out;
    logic        step_tick;
    logic        wave;

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};

    // The slave answers in the cycle after the first access cycle (one wait state); pready drops after each access.
    always_comb begin
        logic access;
        access = psel && penable && !pready;
        next_pready = access;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_clock_select_bit = clock_select_bit;
        next_lower_hold = lower_hold;
        next_width_data = width_data;
        if (access) begin
            case (req.addr)
                PDPWM_OFS_CONTROL: begin
                    if (req.write && req.strb[0]) begin
                        next_clock_select_bit = req.wdata[PDPWM_CLKSEL_POS]; // [RQ3]
                    end
                    next_prdata = {24'h000000, PDPWM_CTRL_RSVD | {7'h00, clock_select_bit}}; // [RQ3]
                end
                PDPWM_OFS_LOWER: begin
                    if (req.write && req.strb[0]) begin
                        next_lower_hold = req.wdata[7:0]; // [RQ4]
                    end
                    next_prdata = {24'h000000, PDPWM_DATA_READ}; // [RQ5]
                end
                PDPWM_OFS_UPPER: begin
                    if (req.write && req.strb[0]) begin
                        // Upper two bits stay set as in the reset pattern.
                        next_width_data = {PDPWM_WIDTH_RESET[15:14], req.wdata[5:0], lower_hold}; // [RQ4] [RQ8]
                    end
                    next_prdata = {24'h000000, PDPWM_DATA_READ}; // [RQ5]
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Register file and bus answer flops.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready           <= 1'b0;
            prdata           <= 32'h0000_0000;
            pslverr          <= 1'b0;
            clock_select_bit <= 1'b0;
            lower_hold       <= PDPWM_WIDTH_RESET[7:0];
            width_data       <= PDPWM_WIDTH_RESET; // [RQ9]
        end else begin
            pready           <= next_pready;
            prdata           <= next_prdata;
            pslverr          <= next_pslverr;
            clock_select_bit <= next_clock_select_bit;
            lower_hold       <= next_lower_hold;
            width_data       <= next_width_data;
        end
    end

    pdpwm_step_gen u_step (
        .clk              (clk),
        .reset            (reset),
        .clock_select_bit (clock_select_bit),
        .step_tick        (step_tick)
    );

    pdpwm_wave_gen u_wave (
        .clk        (clk),
        .reset      (reset),
        .step_tick  (step_tick),
        .width_data (width_data),
        .wave       (wave)
    );

    // Output flop keeps the pin glitch-free.
    assign next_pwm_out = wave;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= next_pwm_out;
        end
    end
endmodule // pdpwm_top
`default_nettype wire

// ---- verification/pdpwm_sva.sv ----
// Checker of APB answers and read-back values of the PWM top.
`timescale 1ns/1ps
`default_nettype none
module pdpwm_sva
    import pdpwm_pkg::*;
(
    // Clock, reset, APB and waveform.
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        pwm_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Decode kept here so that each property fits on one line.
    logic map, rdd;
    assign map = paddr inside {PDPWM_OFS_CONTROL, PDPWM_OFS_UPPER, PDPWM_OFS_LOWER};
    assign rdd = pready && !pwrite && map && paddr != PDPWM_OFS_CONTROL;
    chk_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    chk_ready_once: assert property (pready |=> !pready) else $error("long answer");
    chk_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray answer");
    chk_idle_quiet: assert property (!psel |-> !pready) else $error("idle answer");
    chk_data_ones: assert property (rdd |-> prdata[7:0] == PDPWM_DATA_READ) else $error("data read");
    chk_ctrl_ones: assert property (pready && !pwrite && paddr == PDPWM_OFS_CONTROL |-> prdata[7:1] == 7'h7f)
        else $error("reserved bits");
    chk_bad_addr: assert property (pready && !map |-> pslverr) else $error("no error");
    chk_good_addr: assert property (pready && map |-> !pslverr) else $error("false error");
    // Main scenarios: refused access, upper write and a running waveform.
    cover property (pready && pslverr);
    cover property (pready && pwrite && paddr == PDPWM_OFS_UPPER);
    cover property ($rose(pwm_out));
endmodule // pdpwm_sva
bind pdpwm_top pdpwm_sva u_sva (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_out(pwm_out));
`default_nettype wire

// ---- verification/pdpwm_filter.sv ----
// Filter model that integrates the waveform high time over a window.
`timescale 1ns/1ps
`default_nettype none
module pdpwm_filter (
    // Clock, reset, window clear, waveform in and summed high time out.
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clear,
    input  wire logic        pwm_in,
    output var  logic [16:0] high_count
);
    // A counter stands in for the capacitor: summed high time matters, ripple does not.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            high_count <= '0;
        end else begin
            high_count <= clear ? '0 : high_count + 17'(pwm_in);
        end
    end
endmodule // pdpwm_filter
`default_nettype wire

// ---- verification/test_pdpwm.sv ----
// Self-checking bench of the PWM top with its filter model.
`timescale 1ns/1ps
`default_nettype none
module test_pdpwm
    import pdpwm_pkg::*;
;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, pwm_out, clear, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [16:0] high_count;
    logic [13:0] d;
    int          mismatches, checked;
    pdpwm_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_out(pwm_out));
    pdpwm_filter filt (.clk(clk), .reset(reset), .clear(clear), .pwm_in(pwm_out), .high_count(high_count));
    // Clock of 100 MHz.
    initial forever #5 clk = ~clk;
    // APB transfer; the request stays put until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, wd, s};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) mismatches++;
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    // Any whole period holds the same high time, so the window may start anywhere.
    task automatic measure(input int n, input int e, input string nm);
        @(posedge clk) clear <= 1'b1;
        @(posedge clk) clear <= 1'b0;
        repeat (n) @(posedge clk);
        #1 check(nm, e, 32'(high_count));
    endtask
    // High clocks per period: data plus 64 steps, a step being two clocks on the slow select.
    function automatic int high_clk(logic [13:0] v, logic s);
        return (int'(v) + 64) * (s ? 2 : 1);
    endfunction
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // A hang is cut short well after the three waveform windows.
    initial begin
        repeat (105000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    // Reset values, full-high data, then a random width on the slow select.
    initial begin
        reset = 1'b1;
        {clk, psel, penable, pwrite, paddr, pwdata, pstrb, clear} = '0;
        d = 14'($urandom(39735));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        apb(0, PDPWM_OFS_CONTROL, 0, 4'hf);
        check("control", 8'hfe, rd[7:0]);
        apb(0, PDPWM_OFS_UPPER, 0, 4'h1);
        check("upper", 8'hff, rd[7:0]);
        apb(0, PDPWM_OFS_LOWER, 0, 4'h1);
        check("lower", 8'hff, rd[7:0]);
        apb(0, 8'h0c, 0, 4'hf);
        check("unmapped", 1, err);
        measure(16384, high_clk(0, 0), "reset width");
        $display("reset test done");
        apb(1, PDPWM_OFS_CONTROL, {24'h0, 7'($urandom), 1'b0}, 4'hf);
        apb(0, PDPWM_OFS_CONTROL, 0, 4'hf);
        check("control", 8'hfe, rd[7:0]);
        apb(1, PDPWM_OFS_LOWER, {24'h0, 2'b11, 6'($urandom)}, 4'h1);
        apb(1, PDPWM_OFS_UPPER, 32'h3f, 4'h1);
        repeat (16424) @(posedge clk);
        measure(1024, 1024, "full high");
        $display("full high test done");
        if (d >= 14'h3fc0) d = 14'h3fbf;
        apb(1, PDPWM_OFS_CONTROL, 1, 4'hf);
        apb(0, PDPWM_OFS_CONTROL, 0, 4'hf);
        check("select", 8'hff, rd[7:0]);
        apb(1, PDPWM_OFS_LOWER, {24'h0, d[7:0]}, 4'h1);
        apb(1, PDPWM_OFS_UPPER, 32'hff, 4'h0);
        apb(1, PDPWM_OFS_UPPER, {24'h0, 2'($urandom), d[13:8]}, 4'h1);
        repeat (32808) @(posedge clk);
        measure(32768, high_clk(d, 1), "slow width");
        $display("slow width test done");
        stop_test();
    end
endmodule // test_pdpwm
`default_nettype wire
